// *** rtl/csc_pkg.sv ***
// package: register map, field layout and encodings of the clock configuration block
package csc_pkg;
  localparam logic [11:0] CSC_CFG_OFFSET = 12'h004;
  localparam logic [11:0] CSC_CTRL_OFFSET = 12'h000;
  localparam logic [31:0] CSC_CFG_RESET = 32'h20000000;
  localparam int CSC_CLKOUT_PRES_MSB = 31;
  localparam int CSC_CLKOUT_PRES_LSB = 28;
  localparam int CSC_CLKOUT_SEL_MSB = 27;
  localparam int CSC_CLKOUT_SEL_LSB = 25;
  localparam int CSC_LOOP_SRC_BIT = 24;
  localparam int CSC_LOOP_ODIV_MSB = 23;
  localparam int CSC_LOOP_ODIV_LSB = 22;
  localparam int CSC_LOOP_PRE_MSB = 21;
  localparam int CSC_LOOP_PRE_LSB = 20;
  localparam int CSC_BUS_PRE_MSB = 7;
  localparam int CSC_BUS_PRE_LSB = 4;
  localparam int CSC_STS_MSB_BIT = 3;
  localparam int CSC_SW_MSB = 2;
  localparam int CSC_SW_LSB = 0;
  // ctrl word (own layout): bit0 loop enable, bit1 clock security enable
  localparam int CSC_CTRL_LOOP_EN_BIT = 0;
  localparam int CSC_CTRL_SEC_EN_BIT = 1;
  localparam int CSC_CTRL_STS_LO_MSB = 9;
  localparam int CSC_CTRL_STS_LO_LSB = 8;
  localparam int CSC_CTRL_FIO_EN_BIT = 16;
  localparam logic [3:0] CSC_PRES_MIN = 4'h2;
  localparam logic [3:0] CSC_BUS_PRE_MAX = 4'hF;
  localparam int CSC_BUS_PRE_MAX_DIV = 512;
  localparam int CSC_SWITCH_CYCLES = 4;
  typedef enum logic [2:0] {
    CSC_SRC_FIO = 3'h0,
    CSC_SRC_FEO = 3'h1,
    CSC_SRC_LOOP = 3'h2,
    CSC_SRC_SEO = 3'h3,
    CSC_SRC_SIO = 3'h4
  } csc_src_t;
  typedef enum logic [2:0] {
    CSC_OUT_NONE = 3'h0,
    CSC_OUT_SIO = 3'h1,
    CSC_OUT_SEO = 3'h2,
    CSC_OUT_SYS = 3'h3,
    CSC_OUT_FIO = 3'h4,
    CSC_OUT_FEO = 3'h5,
    CSC_OUT_LOOP = 3'h6
  } csc_out_t;
endpackage

// *** rtl/csc_divider.sv ***
// module: enable-pulse divider by a programmable ratio
`timescale 1ns/10ps
module csc_divider #(
  parameter int WIDTH = 10
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // control
  input wire logic i_tick,
  input wire logic [WIDTH-1:0] i_ratio,
  // result
  output logic o_pulse
);
  logic [WIDTH-1:0] count_q;

  // a ratio change is compared against the running count at once, so one period may be short
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      count_q <= '0;
      o_pulse <= 1'b0;
    end
    else
    begin
      o_pulse <= 1'b0;
      if (i_tick)
      begin
        if (count_q + 1'b1 >= i_ratio)
        begin
          count_q <= '0;
          o_pulse <= 1'b1;
        end
        else
        begin
          count_q <= count_q + 1'b1;
        end
      end
    end
  end
endmodule // csc_divider

// *** rtl/csc_switcher.sv ***
// module: system clock source switch sequencer with completion status
`timescale 1ns/10ps
module csc_switcher
  import csc_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // request
  input wire csc_pkg::csc_src_t i_request,
  // status
  output csc_pkg::csc_src_t o_active,
  output logic o_busy
);
  typedef enum {CSC_SW_IDLE, CSC_SW_WAIT} csc_sw_state_t;
  csc_sw_state_t state_q;
  csc_src_t target_q;
  logic [2:0] wait_q;

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_q <= CSC_SW_IDLE;
      target_q <= CSC_SRC_FIO;
      o_active <= CSC_SRC_FIO;
      wait_q <= '0;
    end
    else
    begin
      case (state_q)
        CSC_SW_IDLE:
        begin
          if (i_request != o_active)
          begin
            target_q <= i_request;
            wait_q <= 3'(CSC_SWITCH_CYCLES - 1);
            state_q <= CSC_SW_WAIT;
          end
        end
        CSC_SW_WAIT:
        begin
          if (wait_q == 3'h0)
          begin
            o_active <= target_q;
            state_q <= CSC_SW_IDLE;
          end
          else
          begin
            wait_q <= wait_q - 3'h1;
          end
        end
        default:
        begin
          state_q <= CSC_SW_IDLE;
        end
      endcase
    end
  end

  assign o_busy = (state_q == CSC_SW_WAIT);
endmodule // csc_switcher

// *** rtl/csc_top.sv ***
// module: clock configuration register, clock output selection and source switch control
`timescale 1ns/10ps
module csc_top
  import csc_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // power mode and oscillator events
  input wire logic i_stop_exit,
  input wire logic i_wake_exit,
  input wire logic i_fast_ext_fail,
  // oscillator clock ticks sampled on the core clock
  input wire logic i_tick_sio,
  input wire logic i_tick_seo,
  input wire logic i_tick_fio,
  input wire logic i_tick_feo,
  input wire logic i_tick_loop,
  // clock outputs and controls
  output logic o_clkout,
  output logic o_loop_pre_tick,
  output logic o_loop_out_tick,
  output logic o_bus_tick,
  output csc_pkg::csc_src_t o_sys_source,
  output logic o_loop_input_source,
  output logic o_fast_internal_osc_enable,
  output logic o_switch_busy
);
  logic [3:0] clkout_prescaler_q;
  logic [2:0] clkout_select_q;
  logic loop_input_source_q;
  logic [1:0] loop_output_divider_q;
  logic [1:0] loop_prescaler_q;
  logic [3:0] bus_prescaler_q;
  logic [2:0] sys_source_switch_q;
  logic loop_enable_q;
  logic clock_security_enable_q;
  logic fast_internal_osc_enable_q;
  logic [31:0] cfg_word;
  logic [31:0] ctrl_word;
  logic wr_access;
  logic rd_access;
  logic hit_cfg;
  logic hit_ctrl;
  logic force_fio;
  csc_src_t active_src;
  logic sel_tick;
  logic pres_pulse;
  logic odiv_pulse;
  logic bus_pulse;
  logic clkout_q;
  logic [9:0] clkout_ratio;
  logic [9:0] loop_pre_ratio;
  logic [9:0] loop_odiv_ratio;
  logic [9:0] bus_ratio;
  logic loop_ref_tick;

  // small ratio decode shared by the two loop dividers
  function automatic logic [9:0] csc_ratio_from_code(input logic [1:0] code);
    csc_ratio_from_code = 10'(code) + 10'h1;
  endfunction

  // bus prescaler: codes 8..14 map to 2,4,...,128 and code 15 to 512; below 8 passes through
  function automatic logic [9:0] csc_bus_ratio(input logic [3:0] code);
    if (code[3])
      csc_bus_ratio = 10'(10'h2 << code[2:0]);
    else
      csc_bus_ratio = 10'h1;
    if (code == CSC_BUS_PRE_MAX)
      csc_bus_ratio = 10'(CSC_BUS_PRE_MAX_DIV);
  endfunction

  // reserved switch codes would name a source that does not exist, so they are dropped
  function automatic logic csc_src_legal(input logic [2:0] code);
    csc_src_legal = (code <= CSC_SRC_SIO);
  endfunction

  // single-cycle apb answer: no wait states
  assign wr_access = i_psel && i_penable && i_pwrite;
  assign rd_access = i_psel && !i_pwrite;
  assign hit_cfg = (i_paddr == CSC_CFG_OFFSET);
  assign hit_ctrl = (i_paddr == CSC_CTRL_OFFSET);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit_cfg && !hit_ctrl;

  // hardware forcing wins over a software write in the same cycle
  assign force_fio = i_stop_exit || (i_fast_ext_fail && clock_security_enable_q);

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      clkout_prescaler_q <= CSC_CFG_RESET[CSC_CLKOUT_PRES_MSB:CSC_CLKOUT_PRES_LSB];
      clkout_select_q <= CSC_CFG_RESET[CSC_CLKOUT_SEL_MSB:CSC_CLKOUT_SEL_LSB];
    end
    else if (wr_access && hit_cfg)
    begin
      clkout_prescaler_q <= i_pwdata[CSC_CLKOUT_PRES_MSB:CSC_CLKOUT_PRES_LSB];
      clkout_select_q <= i_pwdata[CSC_CLKOUT_SEL_MSB:CSC_CLKOUT_SEL_LSB];
    end
  end

  // the output divider may change while the loop runs; only source and prescaler freeze
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      loop_output_divider_q <= CSC_CFG_RESET[CSC_LOOP_ODIV_MSB:CSC_LOOP_ODIV_LSB];
    end
    else if (wr_access && hit_cfg)
    begin
      loop_output_divider_q <= i_pwdata[CSC_LOOP_ODIV_MSB:CSC_LOOP_ODIV_LSB];
    end
  end

  // bus prescaler placement is our own; only its top code has a fixed ratio
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      bus_prescaler_q <= CSC_CFG_RESET[CSC_BUS_PRE_MSB:CSC_BUS_PRE_LSB];
    end
    else if (wr_access && hit_cfg)
    begin
      bus_prescaler_q <= i_pwdata[CSC_BUS_PRE_MSB:CSC_BUS_PRE_LSB];
    end
  end

  // loop source and prescaler are frozen while the loop runs
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      loop_input_source_q <= CSC_CFG_RESET[CSC_LOOP_SRC_BIT];
      loop_prescaler_q <= CSC_CFG_RESET[CSC_LOOP_PRE_MSB:CSC_LOOP_PRE_LSB];
    end
    else if (wr_access && hit_cfg && !loop_enable_q)
    begin
      loop_input_source_q <= i_pwdata[CSC_LOOP_SRC_BIT];
      loop_prescaler_q <= i_pwdata[CSC_LOOP_PRE_MSB:CSC_LOOP_PRE_LSB];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sys_source_switch_q <= CSC_CFG_RESET[CSC_SW_MSB:CSC_SW_LSB];
    end
    else if (force_fio)
    begin
      sys_source_switch_q <= CSC_SRC_FIO;
    end
    else if (wr_access && hit_cfg && csc_src_legal(i_pwdata[CSC_SW_MSB:CSC_SW_LSB]))
    begin
      sys_source_switch_q <= i_pwdata[CSC_SW_MSB:CSC_SW_LSB];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      loop_enable_q <= 1'b0;
      clock_security_enable_q <= 1'b0;
    end
    else if (wr_access && hit_ctrl)
    begin
      // loop cannot be stopped while it feeds the system clock
      loop_enable_q <= i_pwdata[CSC_CTRL_LOOP_EN_BIT] || (active_src == CSC_SRC_LOOP);
      clock_security_enable_q <= i_pwdata[CSC_CTRL_SEC_EN_BIT];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      fast_internal_osc_enable_q <= 1'b1;
    end
    else if (i_wake_exit || i_stop_exit || i_fast_ext_fail)
    begin
      fast_internal_osc_enable_q <= 1'b1;
    end
    else if (wr_access && hit_ctrl)
    begin
      fast_internal_osc_enable_q <= i_pwdata[CSC_CTRL_FIO_EN_BIT]
                                    || (active_src == CSC_SRC_FIO);
    end
  end

  csc_switcher u_switcher (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_request(csc_src_t'(sys_source_switch_q)),
    .o_active(active_src),
    .o_busy(o_switch_busy)
  );

  always_comb
  begin
    cfg_word = '0;
    cfg_word[CSC_CLKOUT_PRES_MSB:CSC_CLKOUT_PRES_LSB] = clkout_prescaler_q;
    cfg_word[CSC_CLKOUT_SEL_MSB:CSC_CLKOUT_SEL_LSB] = clkout_select_q;
    cfg_word[CSC_LOOP_SRC_BIT] = loop_input_source_q;
    cfg_word[CSC_LOOP_ODIV_MSB:CSC_LOOP_ODIV_LSB] = loop_output_divider_q;
    cfg_word[CSC_LOOP_PRE_MSB:CSC_LOOP_PRE_LSB] = loop_prescaler_q;
    cfg_word[CSC_BUS_PRE_MSB:CSC_BUS_PRE_LSB] = bus_prescaler_q;
    cfg_word[CSC_STS_MSB_BIT] = active_src[2];
    cfg_word[CSC_SW_MSB:CSC_SW_LSB] = sys_source_switch_q;
  end

  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[CSC_CTRL_LOOP_EN_BIT] = loop_enable_q;
    ctrl_word[CSC_CTRL_SEC_EN_BIT] = clock_security_enable_q;
    ctrl_word[CSC_CTRL_STS_LO_MSB:CSC_CTRL_STS_LO_LSB] = active_src[1:0];
    ctrl_word[CSC_CTRL_FIO_EN_BIT] = fast_internal_osc_enable_q;
  end

  // read data is registered in the setup cycle so it is stable in the access phase
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_prdata <= '0;
    end
    else if (rd_access && !i_penable)
    begin
      o_prdata <= hit_cfg ? cfg_word : (hit_ctrl ? ctrl_word : 32'h00000000);
    end
  end

  // output source mux: switching mid-period can cut a pulse short, no glitch guard
  always_comb
  begin
    case (clkout_select_q)
      CSC_OUT_NONE: sel_tick = 1'b0;
      CSC_OUT_SIO: sel_tick = i_tick_sio;
      CSC_OUT_SEO: sel_tick = i_tick_seo;
      CSC_OUT_SYS: sel_tick = 1'b1;
      CSC_OUT_FIO: sel_tick = i_tick_fio;
      CSC_OUT_FEO: sel_tick = i_tick_feo;
      CSC_OUT_LOOP: sel_tick = pres_pulse;
      default: sel_tick = 1'b0;
    endcase
  end

  // codes 0 and 1 are not allowed for the output prescaler; they run as the smallest ratio
  assign clkout_ratio = (clkout_prescaler_q < CSC_PRES_MIN) ? 10'(CSC_PRES_MIN)
                        : 10'(clkout_prescaler_q);
  assign loop_pre_ratio = csc_ratio_from_code(loop_prescaler_q);
  assign loop_odiv_ratio = csc_ratio_from_code(loop_output_divider_q);
  assign bus_ratio = csc_bus_ratio(bus_prescaler_q);
  // the reference follows the frozen source bit, so it cannot move under a running loop
  assign loop_ref_tick = loop_input_source_q ? i_tick_feo : i_tick_fio;

  csc_divider #(.WIDTH(10)) u_clkout_pres (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_tick(i_tick_loop),
    .i_ratio(clkout_ratio),
    .o_pulse(pres_pulse)
  );

  csc_divider #(.WIDTH(10)) u_loop_pre (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_tick(loop_ref_tick),
    .i_ratio(loop_pre_ratio),
    .o_pulse(o_loop_pre_tick)
  );

  csc_divider #(.WIDTH(10)) u_loop_odiv (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_tick(i_tick_loop),
    .i_ratio(loop_odiv_ratio),
    .o_pulse(odiv_pulse)
  );

  csc_divider #(.WIDTH(10)) u_bus_pre (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_tick(1'b1),
    .i_ratio(bus_ratio),
    .o_pulse(bus_pulse)
  );

  // toggling output; may emit short pulses on startup or source change
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      clkout_q <= 1'b0;
    end
    else if (clkout_select_q == CSC_OUT_NONE)
    begin
      clkout_q <= 1'b0;
    end
    else if (sel_tick)
    begin
      clkout_q <= ~clkout_q;
    end
  end

  assign o_clkout = clkout_q;
  assign o_loop_out_tick = odiv_pulse;
  assign o_bus_tick = bus_pulse;
  assign o_sys_source = active_src;
  assign o_loop_input_source = loop_input_source_q;
  assign o_fast_internal_osc_enable = fast_internal_osc_enable_q;
endmodule // csc_top

// *** dv/csc_top_chk.sv ***
// checker: concurrent assertions on the clock configuration block ports
`timescale 1ns/10ps
module csc_top_chk
  import csc_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // events and status
  input wire logic i_stop_exit,
  input wire logic i_wake_exit,
  input wire logic i_fast_ext_fail,
  input wire csc_pkg::csc_src_t o_sys_source,
  input wire logic o_fast_internal_osc_enable,
  input wire logic o_switch_busy
);
  logic unmap;
  assign unmap = (i_paddr != CSC_CFG_OFFSET) && (i_paddr != CSC_CTRL_OFFSET);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_busy_run;
    o_switch_busy [*4] ##1 !o_switch_busy;
  endsequence
  sequence s_rd_setup;
    i_psel && !i_penable && !i_pwrite;
  endsequence
  AST_SWITCH_LEN: assert property ($rose(o_switch_busy) |-> s_busy_run)
    else $error("switch busy length wrong");
  AST_SRC_AT_END: assert property ($changed(o_sys_source) |-> $fell(o_switch_busy))
    else $error("source status changed before switch end");
  AST_FORCE_EN: assert property ((i_stop_exit || i_wake_exit || i_fast_ext_fail)
    |=> o_fast_internal_osc_enable) else $error("internal osc enable not set");
  AST_STOP_SW: assert property ((i_stop_exit && o_sys_source != CSC_SRC_FIO &&
    !o_switch_busy) |-> ##[1:3] o_switch_busy) else $error("stop exit did not switch");
  AST_UNMAP_ERR: assert property ((i_psel && i_penable && unmap) |-> o_pslverr)
    else $error("no error on unmapped access");
  AST_MAP_OK: assert property ((i_psel && i_penable && !unmap) |-> !o_pslverr)
    else $error("error on mapped access");
  AST_UNMAP_ZERO: assert property (s_rd_setup ##1 (i_penable && unmap) |-> o_prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_PRDATA_HOLD: assert property (!(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata))
    else $error("read data moved outside a read");
  AST_PREADY: assert property (o_pready)
    else $error("ready low");
endmodule // csc_top_chk

bind csc_top csc_top_chk csc_top_chk_inst (.i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_stop_exit(i_stop_exit), .i_wake_exit(i_wake_exit), .i_fast_ext_fail(i_fast_ext_fail),
  .o_sys_source(o_sys_source), .o_fast_internal_osc_enable(o_fast_internal_osc_enable),
  .o_switch_busy(o_switch_busy));

// *** dv/tb.sv ***
// testbench: register, divider and source switch scenarios for the clock configuration block
`timescale 1ns/10ps
module tb;
  import csc_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, stop, wake, fail, loop_tk;
  logic clkout, pre_tk, out_tk, bus_tk, lis, fio_en, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] tk = 4'h0;
  csc_src_t src;
  int errors, compares;
  csc_top csc_top_inst (.i_core_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_stop_exit(stop), .i_wake_exit(wake),
    .i_fast_ext_fail(fail), .i_tick_sio(tk == 4'h0), .i_tick_seo(tk == 4'h8),
    .i_tick_fio(tk[0]), .i_tick_feo(tk[1]), .i_tick_loop(loop_tk), .o_clkout(clkout),
    .o_loop_pre_tick(pre_tk), .o_loop_out_tick(out_tk), .o_bus_tick(bus_tk),
    .o_sys_source(src), .o_loop_input_source(lis), .o_fast_internal_osc_enable(fio_en),
    .o_switch_busy(busy));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) tk <= tk + 4'h1;
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin errors++; $display("BAD %s exp %h got %h", nm, exp, got); end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin errors++; $display("BAD pready exp 1 got %b", pready); end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(nm, exp, r);
  endtask
  task wait_idle;
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (busy !== 1'b0 && n < 50) begin @(posedge clk); n++; end
    #1 chk("busy_end", 1'b0, busy);
  endtask
  task pulse(input int k);
    @(posedge clk);
    if (k == 0) stop <= 1'b1; else if (k == 1) wake <= 1'b1; else fail <= 1'b1;
    @(posedge clk);
    stop <= 1'b0; wake <= 1'b0; fail <= 1'b0;
  endtask
  // gap between the 2nd and 3rd event, so a stale count from the old setting is skipped
  task gap(input int k, input int exp, input string nm);
    int n, hits;
    logic cur, prev;
    n = 0; hits = 0; prev = clkout;
    while (hits < 3 && n < 2000) begin
      @(posedge clk); #1;
      cur = (k == 0) ? out_tk : (k == 1) ? bus_tk : (k == 3) ? pre_tk : (clkout !== prev);
      prev = clkout;
      n++;
      if (cur === 1'b1) begin hits++; if (hits < 3) n = 0; end
    end
    chk(nm, exp, n);
  endtask
  task t_reset_map;
    rd("cfg_rst", CSC_CFG_OFFSET, CSC_CFG_RESET);
    rd("ctrl_rst", CSC_CTRL_OFFSET, 32'h00010000);
    wr(12'h008, 32'hFFFFFFFF);
    rd("unmapped", 12'h008, 32'h0);
    rd("cfg_kept", CSC_CFG_OFFSET, CSC_CFG_RESET);
    $display("test reset_map done");
  endtask
  task t_loop_lock;
    wr(CSC_CFG_OFFSET, 32'h21300000);
    rd("cfg_src_pre", CSC_CFG_OFFSET, 32'h21300000);
    #1 chk("lis_ext", 1'b1, lis);
    wr(CSC_CTRL_OFFSET, 32'h00010001);
    wr(CSC_CFG_OFFSET, 32'h20000000);
    rd("cfg_locked", CSC_CFG_OFFSET, 32'h21300000);
    wr(CSC_CTRL_OFFSET, 32'h00010000);
    wr(CSC_CFG_OFFSET, 32'h20000000);
    rd("cfg_free", CSC_CFG_OFFSET, 32'h20000000);
    #1 chk("lis_int", 1'b0, lis);
    wr(CSC_CFG_OFFSET, 32'h20200000);
    gap(3, 6, "pre_div3");
    $display("test loop_lock done");
  endtask
  task t_dividers;
    wr(CSC_CFG_OFFSET, 32'h26C000F0);
    gap(0, 4, "loop_div4");
    gap(1, 512, "bus_div512");
    gap(2, 1, "clkout_sys");
    wr(CSC_CFG_OFFSET, 32'h5C000000);
    gap(0, 1, "loop_div1");
    gap(2, 5, "clkout_div5");
    wr(CSC_CFG_OFFSET, 32'h20000000);
    repeat (3) @(posedge clk);
    repeat (8) begin @(posedge clk); #1 chk("clkout_off", 1'b0, clkout); end
    $display("test dividers done");
  endtask
  task t_switch;
    wr(CSC_CFG_OFFSET, 32'h20000001);
    #1 chk("src_hold", CSC_SRC_FIO, src);
    wait_idle();
    chk("src_feo", CSC_SRC_FEO, src);
    rd("cfg_feo", CSC_CFG_OFFSET, 32'h20000001);
    rd("ctrl_feo", CSC_CTRL_OFFSET, 32'h00010100);
    wr(CSC_CFG_OFFSET, 32'h20000004);
    wait_idle();
    chk("src_sio", CSC_SRC_SIO, src);
    rd("cfg_sio", CSC_CFG_OFFSET, 32'h2000000C);
    rd("ctrl_sio", CSC_CTRL_OFFSET, 32'h00010000);
    wr(CSC_CFG_OFFSET, 32'h20000007);
    rd("sw_reserved", CSC_CFG_OFFSET, 32'h2000000C);
    $display("test switch done");
  endtask
  task t_force;
    wr(CSC_CTRL_OFFSET, 32'h0);
    rd("osc_off", CSC_CTRL_OFFSET, 32'h0);
    pulse(1);
    rd("osc_wake", CSC_CTRL_OFFSET, 32'h00010000);
    pulse(2);
    rd("fail_nosec", CSC_CFG_OFFSET, 32'h2000000C);
    wr(CSC_CTRL_OFFSET, 32'h00010002);
    pulse(2);
    wait_idle();
    rd("fail_sec", CSC_CFG_OFFSET, 32'h20000000);
    chk("src_fail", CSC_SRC_FIO, src);
    wr(CSC_CFG_OFFSET, 32'h20000001);
    wait_idle();
    pulse(0);
    wait_idle();
    rd("stop_sw", CSC_CFG_OFFSET, 32'h20000000);
    chk("src_stop", CSC_SRC_FIO, src);
    chk("osc_stop", 1'b1, fio_en);
    $display("test force done");
  endtask
  task complete_run;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    errors = 0; compares = 0; rst = 1'b1; loop_tk = 1'b1;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    stop = 1'b0; wake = 1'b0; fail = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset_map();
    t_loop_lock();
    t_dividers();
    t_switch();
    t_force();
    complete_run();
  end
  // whole sequence takes well under 10k cycles
  initial
  begin
    #200000;
    errors++;
    complete_run();
  end
endmodule // tb
